// [rtl/cte_regs.svh]
/*
 * register offsets, field positions, reset values and timing counts
 * of the event-action and interrupt-enable block.
 * assumes: included by bare name from the top module and the bench.
 */
`ifndef CTE_REGS_SVH
`define CTE_REGS_SVH

`define CTE_OFF_ACTION    12'h020
`define CTE_OFF_MASK_CLR  12'h024
`define CTE_OFF_MASK_SET  12'h028
`define CTE_OFF_FLAGS     12'h02c

`define CTE_ACTION_RST    32'h0000_0000
`define CTE_MASK_RST      32'h0000_0000
`define CTE_FLAGS_RST     32'h0000_0000

`define CTE_ACT0_LSB      0
`define CTE_ACT0_MSB      2
`define CTE_ACT1_LSB      3
`define CTE_ACT1_MSB      5
`define CTE_ACTION_VALID  32'h0000_003f

`define CTE_BIT_WRAP      0
`define CTE_BIT_RESTART   1
`define CTE_BIT_CYCLE     2
`define CTE_BIT_CAPERR    3
`define CTE_BIT_HALT      11
`define CTE_BIT_SOFT_A    12
`define CTE_BIT_SOFT_B    13
`define CTE_BIT_HARD0     14
`define CTE_BIT_HARD1     15
`define CTE_BIT_CHAN_LSB  16
`define CTE_BIT_CHAN_MSB  19
`define CTE_IRQ_VALID     32'h000f_f80f

`define CTE_ACT_OFF       3'h0
`define CTE_ACT_RESTART   3'h1
`define CTE_ACT0_TALLY    3'h2
`define CTE_ACT0_START    3'h3
`define CTE_ACT0_INC      3'h4
`define CTE_ACT0_GATE     3'h5
`define CTE_ACT0_RSVD     3'h6
`define CTE_ACT1_DIR      3'h2
`define CTE_ACT1_STOP     3'h3
`define CTE_ACT1_DOWN     3'h4
`define CTE_ACT1_PTW      3'h5
`define CTE_ACT1_WTP      3'h6
`define CTE_ACT_FAULT     3'h7

`define CTE_TICK_DIV      4
`define CTE_DIV_W         2

`endif

// [rtl/cte_pkg.sv]
/*
 * types shared by the event-action and interrupt-enable block.
 * assumes: cte_regs.svh holds the numbers.
 */
`default_nettype none
package cte_pkg;
   typedef logic [2:0] cte_act_t;
   typedef logic [31:0] cte_word_t;
   typedef logic [11:0] cte_addr_t;
endpackage
`default_nettype wire

// [rtl/cte_sync.sv]
/*
 * three-stage synchroniser for one asynchronous event pin; the output
 * level changes only once stages two and three agree.
 * assumes: one clock pclk, asynchronous active-low reset.
 */
`default_nettype none
module cte_sync (
   input wire logic pclk,    // clock
   input wire logic presetn, // async reset, low
   input wire logic pin,     // asynchronous level
   output logic lvl          // filtered level
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic lvl_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_ff <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         lvl_ff <= s3_ff;
      end
   end

   assign lvl = lvl_ff;
endmodule // cte_sync
`default_nettype wire

// [rtl/cte_top.sv]
/*
 * event-input action decode and interrupt enable/flag registers of the
 * control timer, reached over apb.
 * assumes: counter core consumes the action outputs and reports flag
 * conditions as one-cycle pulses on pclk; event pins are asynchronous.
 */
// Added by the designer: the APB register port.
// Contract
// - input one field bits 5:3, 7 faults
// - code 0 idle, code 1 restarts counter
// - input one: direction, stop, decrement
// - input one: period/width capture orders
// - input zero field bits 2:0, 6 reserved
// - input zero: count, start, increment
// - input zero: gated count, fault
// - clear port ones clear enables
// - zeros leave enables unchanged
// - both mask ports read one state
// - channel enables at bits 16-19
// - fault enables at bits 11-15
// - wrap, restart, cycle, error at 0-3
// - set port ones set enables
// - flags set next count tick, w1c
`default_nettype none
`include "cte_regs.svh"
module cte_top
   import cte_pkg::*;
(
   input wire logic pclk,                // apb clock 50 mhz
   input wire logic presetn,             // async reset, low
   input wire logic psel,                // apb select
   input wire logic penable,             // apb access phase
   input wire logic pwrite,              // apb write
   input wire logic [11:0] paddr,        // apb byte address
   input wire logic [31:0] pwdata,       // apb write data
   output logic [31:0] prdata,           // apb read data
   output logic pready,                  // apb ready
   output logic pslverr,                 // apb error, unmapped
   input wire logic write_protect,       // action and mask write protection
   input wire logic event_input_zero,    // async event pin 0
   input wire logic event_input_one,     // async event pin 1
   input wire logic [3:0] cond_channel,  // channel hit pulses
   input wire logic cond_soft_a,         // soft stop a pulse
   input wire logic cond_soft_b,         // soft stop b pulse
   input wire logic cond_halt,           // debug halt fault pulse
   input wire logic [1:0] cond_hard,     // hard stop pulses
   input wire logic cond_cap_err,        // capture error pulse
   input wire logic cond_cycle,          // counter cycle pulse
   input wire logic cond_restart,        // retrigger pulse
   input wire logic cond_wrap,           // overflow pulse
   output logic count_clock,             // count tick enable
   output logic restart_req,             // restart pulse
   output logic tally_on_event,          // count step pulse
   output logic start_req,               // start pulse
   output logic inc_req,                 // increment pulse
   output logic count_gate,              // count while high
   output logic stop_req,                // stop pulse
   output logic count_down_step,         // decrement pulse
   output logic dir_down,                // direction level
   output logic period_then_width,       // capture order level
   output logic width_then_period,       // capture order level
   output logic cap_rise,                // capture on rise pulse
   output logic cap_fall,                // capture on fall pulse
   output logic [1:0] hard_stop_req,     // fault pulses
   output logic irq                      // interrupt level
);
   cte_word_t action_ff, mask_ff, flags_ff, pend_ff, prdata_ff;
   cte_word_t cond, rd_word;
   cte_act_t act0, act1;
   logic [`CTE_DIV_W-1:0] div_ff;
   logic tick_ff, wr_en, mapped;
   logic ev0_lvl, ev1_lvl, ev0_prev_ff, ev1_prev_ff;
   logic ev0_rise, ev1_rise, ev1_fall;
   logic restart_ff, tally_ff, start_ff, inc_ff, gate_ff, stop_ff;
   logic down_ff, dir_ff, ptw_ff, wtp_ff, rise_ff, fall_ff;
   logic [1:0] fault_ff;

   // apb decode
   assign mapped = (paddr == `CTE_OFF_ACTION) || (paddr == `CTE_OFF_MASK_CLR) ||
                   (paddr == `CTE_OFF_MASK_SET) || (paddr == `CTE_OFF_FLAGS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign wr_en = psel && penable && pwrite && mapped;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (paddr)
         `CTE_OFF_ACTION: rd_word = action_ff;
         `CTE_OFF_MASK_CLR: rd_word = mask_ff;
         `CTE_OFF_MASK_SET: rd_word = mask_ff;
         `CTE_OFF_FLAGS: rd_word = flags_ff;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // read data latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= rd_word;
      end
   end
   assign prdata = prdata_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         action_ff <= `CTE_ACTION_RST;
      end else if (wr_en && !write_protect && paddr == `CTE_OFF_ACTION) begin
         action_ff <= pwdata & `CTE_ACTION_VALID;
      end
   end
   assign act0 = action_ff[`CTE_ACT0_MSB:`CTE_ACT0_LSB];
   assign act1 = action_ff[`CTE_ACT1_MSB:`CTE_ACT1_LSB];

   // one enable state behind both mask ports
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= `CTE_MASK_RST;
      end else if (wr_en && !write_protect) begin
         if (paddr == `CTE_OFF_MASK_CLR) begin
            mask_ff <= mask_ff & ~(pwdata & `CTE_IRQ_VALID);
         end else if (paddr == `CTE_OFF_MASK_SET) begin
            mask_ff <= mask_ff | (pwdata & `CTE_IRQ_VALID);
         end
      end
   end

   // count clock divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_ff <= div_ff + 1'b1;
         tick_ff <= (div_ff == `CTE_DIV_W'(`CTE_TICK_DIV - 1));
      end
   end
   assign count_clock = tick_ff;

   // flag conditions gathered into the register layout
   always_comb begin
      cond = 32'h0000_0000;
      cond[`CTE_BIT_CHAN_MSB:`CTE_BIT_CHAN_LSB] = cond_channel;
      cond[`CTE_BIT_HARD1] = cond_hard[1] | fault_ff[1];
      cond[`CTE_BIT_HARD0] = cond_hard[0] | fault_ff[0];
      cond[`CTE_BIT_SOFT_B] = cond_soft_b;
      cond[`CTE_BIT_SOFT_A] = cond_soft_a;
      cond[`CTE_BIT_HALT] = cond_halt;
      cond[`CTE_BIT_CAPERR] = cond_cap_err;
      cond[`CTE_BIT_CYCLE] = cond_cycle;
      cond[`CTE_BIT_RESTART] = cond_restart;
      cond[`CTE_BIT_WRAP] = cond_wrap;
   end

   // pending conditions land on the next count tick; set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= 32'h0000_0000;
      end else if (tick_ff) begin
         pend_ff <= cond;
      end else begin
         pend_ff <= pend_ff | cond;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff <= `CTE_FLAGS_RST;
      end else begin
         flags_ff <= ((wr_en && paddr == `CTE_OFF_FLAGS) ? (flags_ff & ~pwdata) : flags_ff)
                     | (tick_ff ? pend_ff : 32'h0000_0000);
      end
   end

   assign irq = |(flags_ff & mask_ff);

   // event pins
   cte_sync u_sync0 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(event_input_zero),
      .lvl(ev0_lvl)
   );
   cte_sync u_sync1 (
      .pclk(pclk),
      .presetn(presetn),
      .pin(event_input_one),
      .lvl(ev1_lvl)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev0_prev_ff <= 1'b0;
         ev1_prev_ff <= 1'b0;
      end else begin
         ev0_prev_ff <= ev0_lvl;
         ev1_prev_ff <= ev1_lvl;
      end
   end
   assign ev0_rise = ev0_lvl && !ev0_prev_ff;
   assign ev1_rise = ev1_lvl && !ev1_prev_ff;
   assign ev1_fall = !ev1_lvl && ev1_prev_ff;

   // action decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         restart_ff <= 1'b0;
         tally_ff <= 1'b0;
         start_ff <= 1'b0;
         inc_ff <= 1'b0;
         gate_ff <= 1'b0;
         fault_ff <= 2'h0;
      end else begin
         restart_ff <= (ev0_rise && act0 == `CTE_ACT_RESTART)
                       || (ev1_rise && act1 == `CTE_ACT_RESTART);
         tally_ff <= ev0_rise && act0 == `CTE_ACT0_TALLY;
         start_ff <= ev0_rise && act0 == `CTE_ACT0_START;
         inc_ff <= ev0_rise && act0 == `CTE_ACT0_INC;
         gate_ff <= ev0_lvl && act0 == `CTE_ACT0_GATE;
         fault_ff[0] <= ev0_rise && act0 == `CTE_ACT_FAULT;
         fault_ff[1] <= ev1_rise && act1 == `CTE_ACT_FAULT;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_ff <= 1'b0;
         down_ff <= 1'b0;
         dir_ff <= 1'b0;
         ptw_ff <= 1'b0;
         wtp_ff <= 1'b0;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else begin
         stop_ff <= ev1_rise && act1 == `CTE_ACT1_STOP;
         down_ff <= ev1_rise && act1 == `CTE_ACT1_DOWN;
         dir_ff <= ev1_lvl && act1 == `CTE_ACT1_DIR;
         ptw_ff <= act1 == `CTE_ACT1_PTW;
         wtp_ff <= act1 == `CTE_ACT1_WTP;
         rise_ff <= ev1_rise && (act1 == `CTE_ACT1_PTW || act1 == `CTE_ACT1_WTP);
         fall_ff <= ev1_fall && (act1 == `CTE_ACT1_PTW || act1 == `CTE_ACT1_WTP);
      end
   end

   assign restart_req = restart_ff;
   assign tally_on_event = tally_ff;
   assign start_req = start_ff;
   assign inc_req = inc_ff;
   assign count_gate = gate_ff;
   assign stop_req = stop_ff;
   assign count_down_step = down_ff;
   assign dir_down = dir_ff;
   assign period_then_width = ptw_ff;
   assign width_then_period = wtp_ff;
   assign cap_rise = rise_ff;
   assign cap_fall = fall_ff;
   assign hard_stop_req = fault_ff;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_ev1_fault;
      ev1_rise && act1 == `CTE_ACT_FAULT;
   endsequence
   sequence s_fault_flag;
      hard_stop_req[1] ##[1:8] flags_ff[`CTE_BIT_HARD1];
   endsequence
   sequence s_mask_wr;
      wr_en && !write_protect;
   endsequence
   property p_fault1;
      s_ev1_fault |=> s_fault_flag;
   endproperty
   a_fault1: assert property (p_fault1) else $error("fault1 missing");
   property p_idle;
      act0 == `CTE_ACT_OFF && act1 == `CTE_ACT_OFF && $stable(action_ff)
         |=> !restart_req && !hard_stop_req[0] && !stop_req;
   endproperty
   a_idle: assert property (p_idle) else $error("action while off");
   property p_restart;
      ev0_rise && act0 == `CTE_ACT_RESTART |=> restart_req;
   endproperty
   a_restart: assert property (p_restart) else $error("restart missing");
   property p_stop_dec;
      ev1_rise && act1 == `CTE_ACT1_STOP |=> stop_req && !count_down_step;
   endproperty
   a_stop_dec: assert property (p_stop_dec) else $error("stop missing");
   property p_dir;
      act1 == `CTE_ACT1_DIR |=> dir_down == $past(ev1_lvl);
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_order;
      act1 == `CTE_ACT1_WTP |=> width_then_period && !period_then_width;
   endproperty
   a_order: assert property (p_order) else $error("capture order wrong");
   property p_reserved;
      act0 == `CTE_ACT0_RSVD && act1 == `CTE_ACT_OFF
         |=> !tally_on_event && !start_req && !inc_req && !count_gate;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved acted");
   property p_inc;
      ev0_rise && act0 == `CTE_ACT0_INC |=> inc_req && !start_req;
   endproperty
   a_inc: assert property (p_inc) else $error("increment missing");
   property p_gate;
      act0 == `CTE_ACT0_GATE && ev0_lvl |=> count_gate;
   endproperty
   a_gate: assert property (p_gate) else $error("gate missing");
   property p_clr;
      (s_mask_wr and paddr == `CTE_OFF_MASK_CLR)
         |=> mask_ff == ($past(mask_ff) & ~($past(pwdata) & `CTE_IRQ_VALID));
   endproperty
   a_clr: assert property (p_clr) else $error("mask clear wrong");
   property p_zero;
      wr_en && pwdata == 32'h0000_0000 && paddr != `CTE_OFF_ACTION |=> $stable(mask_ff);
   endproperty
   a_zero: assert property (p_zero) else $error("zero write changed mask");
   property p_set;
      (s_mask_wr and paddr == `CTE_OFF_MASK_SET)
         |=> mask_ff == ($past(mask_ff) | ($past(pwdata) & `CTE_IRQ_VALID));
   endproperty
   a_set: assert property (p_set) else $error("mask set wrong");
   property p_flag;
      tick_ff && pend_ff[`CTE_BIT_WRAP] |=> flags_ff[`CTE_BIT_WRAP];
   endproperty
   a_flag: assert property (p_flag) else $error("flag not set");
   property p_irq;
      flags_ff[`CTE_BIT_WRAP] && mask_ff[`CTE_BIT_WRAP] |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_protect;
      wr_en && write_protect |=> $stable(mask_ff);
   endproperty
   a_protect: assert property (p_protect) else $error("protected write landed");
endmodule // cte_top
`default_nettype wire

// [sim/cte_partner.sv]
/*
 * model of the far side: event routing network and counter core.
 * assumes: bench asks for one-cycle condition pulses on fire, laid out
 * like the flag register, and for event pin levels on ev_lvl.
 */
`default_nettype none
module cte_partner (
   input wire logic pclk,                // clock
   input wire logic presetn,             // async reset, low
   input wire logic [31:0] fire,         // condition request, flag layout
   input wire logic [1:0] ev_lvl,        // wanted event pin levels
   output logic event_input_zero,        // event pin 0
   output logic event_input_one,         // event pin 1
   output logic [3:0] cond_channel,      // channel hit pulses
   output logic cond_soft_a,             // soft stop a
   output logic cond_soft_b,             // soft stop b
   output logic cond_halt,               // debug halt
   output logic [1:0] cond_hard,         // hard stops
   output logic cond_cap_err,            // capture error
   output logic cond_cycle,              // counter cycle
   output logic cond_restart,            // retrigger
   output logic cond_wrap                // overflow
);
   timeunit 1ns;
   timeprecision 1ps;
   // pulses last one clock, as the core makes them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {event_input_one, event_input_zero} <= 2'h0;
         {cond_channel, cond_hard, cond_soft_b, cond_soft_a, cond_halt} <= 9'h000;
         {cond_cap_err, cond_cycle, cond_restart, cond_wrap} <= 4'h0;
      end else begin
         {event_input_one, event_input_zero} <= ev_lvl;
         {cond_channel, cond_hard, cond_soft_b, cond_soft_a, cond_halt} <= fire[19:11];
         {cond_cap_err, cond_cycle, cond_restart, cond_wrap} <= fire[3:0];
      end
   end
endmodule // cte_partner
`default_nettype wire

// [sim/ctl_timer_event_action_irq_enable_tb.sv]
/*
 * self-checking bench: apb master, event actions, masks, flags, irq.
 * assumes: cte_top answers apb with no wait; partner model drives pins.
 */
`default_nettype none
`include "cte_regs.svh"
module ctl_timer_event_action_irq_enable_tb;
   import cte_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, write_protect = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, fire = 32'h0;
   logic pready, pslverr, irq, count_clock;
   logic [1:0] ev_lvl = 2'h0, hard_stop_req, cond_hard;
   logic ev0, ev1, c_sa, c_sb, c_h, c_ce, c_cy, c_rs, c_wr;
   logic [3:0] c_ch;
   logic [13:0] obs;
   int n_mismatch = 0, cmp_count = 0, seed;
   cte_word_t m, d, r;
   logic e;
   cte_top u_cte_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .write_protect(write_protect), .event_input_zero(ev0),
      .event_input_one(ev1), .cond_channel(c_ch), .cond_soft_a(c_sa), .cond_soft_b(c_sb),
      .cond_halt(c_h), .cond_hard(cond_hard), .cond_cap_err(c_ce), .cond_cycle(c_cy),
      .cond_restart(c_rs), .cond_wrap(c_wr), .count_clock(count_clock),
      .restart_req(obs[0]), .tally_on_event(obs[1]), .start_req(obs[2]), .inc_req(obs[3]),
      .count_gate(obs[4]), .stop_req(obs[5]), .count_down_step(obs[6]), .dir_down(obs[7]),
      .period_then_width(obs[8]), .width_then_period(obs[9]), .cap_rise(obs[10]),
      .cap_fall(obs[11]), .hard_stop_req(hard_stop_req), .irq(irq));
   cte_partner u_cte_partner (.pclk(pclk), .presetn(presetn), .fire(fire), .ev_lvl(ev_lvl),
      .event_input_zero(ev0), .event_input_one(ev1), .cond_channel(c_ch),
      .cond_soft_a(c_sa), .cond_soft_b(c_sb), .cond_halt(c_h), .cond_hard(cond_hard),
      .cond_cap_err(c_ce), .cond_cycle(c_cy), .cond_restart(c_rs), .cond_wrap(c_wr));
   assign obs[13:12] = hard_stop_req;
   initial begin
      forever #10 pclk = ~pclk;
   end
   function automatic cte_word_t exp_valid();
      return 32'h000f_0000 | 32'h0000_c000 | 32'h0000_3000 | 32'h0000_0800 | 32'h0000_000f;
   endfunction
   // expected pulses and levels for one pin toggle; bit order as obs
   function automatic logic [13:0] exp_act(input int pin, input int code);
      logic [13:0] z0 [8] = '{14'h0, 14'h1, 14'h2, 14'h4, 14'h8, 14'h10, 14'h0, 14'h1000};
      logic [13:0] z1 [8] = '{14'h0, 14'h1, 14'h80, 14'h20, 14'h40, 14'hd00, 14'he00, 14'h2000};
      return pin ? z1[code] : z0[code];
   endfunction
   task automatic chk(input cte_word_t got, input cte_word_t exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
         n_mismatch++;
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input cte_word_t wd,
         output cte_word_t rd, output logic err);
      int i;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) close_out(1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input cte_word_t wd);
      apb(1, a, wd, r, e);
   endtask
   task automatic rd_chk(input logic [11:0] a, input cte_word_t exp, input string msg);
      apb(0, a, 32'h0, r, e);
      chk(r, exp, msg);
   endtask
   task automatic wait_irq(input logic lvl);
      for (int i = 0; i < 16 && irq !== lvl; i++) @(posedge pclk);
      chk(irq, lvl, "irq level");
   endtask
   task automatic close_out(input int hung);
      if (hung) n_mismatch++;
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      logic [13:0] acc;
      int n;
      seed = $urandom(32);
      repeat (3) @(posedge pclk);
      presetn <= 1;
      rd_chk(`CTE_OFF_MASK_CLR, 32'h0, "clear port reset");
      rd_chk(`CTE_OFF_MASK_SET, 32'h0, "set port reset");
      $display("test reset done");
      n = 0;
      repeat (40) @(posedge pclk) n += count_clock;
      chk(n, 40 / `CTE_TICK_DIV, "count tick rate");
      $display("test tick done");
      m = 0;
      for (int k = 0; k < 40; k++) begin
         d = (k < 2) ? 32'hffff_ffff : $urandom;
         if ($urandom % 2) begin
            wr(`CTE_OFF_MASK_SET, d);
            m = (m | d) & exp_valid();
         end else begin
            wr(`CTE_OFF_MASK_CLR, d);
            m = m & ~d;
         end
         rd_chk(`CTE_OFF_MASK_CLR, m, "mask via clear port");
         rd_chk(`CTE_OFF_MASK_SET, m, "mask via set port");
      end
      wr(`CTE_OFF_MASK_SET, 32'h0);
      wr(`CTE_OFF_MASK_CLR, 32'h0);
      rd_chk(`CTE_OFF_MASK_SET, m, "zero writes");
      wr(`CTE_OFF_MASK_SET, 32'h0001_0001);
      m = m | 32'h0001_0001;
      write_protect <= 1;
      wr(`CTE_OFF_MASK_CLR, 32'hffff_ffff);
      wr(`CTE_OFF_MASK_SET, 32'hffff_ffff);
      rd_chk(`CTE_OFF_MASK_SET, m, "protected writes");
      write_protect <= 0;
      apb(0, 12'h030, 32'h0, r, e);
      chk(e, 1, "unmapped error");
      wr(`CTE_OFF_MASK_CLR, 32'hffff_ffff);
      $display("test masks done");
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 8; c++) begin
            wr(`CTE_OFF_ACTION, c << (3 * p));
            acc = 0;
            ev_lvl[p] <= 1;
            repeat (10) @(posedge pclk) acc |= obs;
            ev_lvl[p] <= 0;
            repeat (10) @(posedge pclk) acc |= obs;
            chk(acc, exp_act(p, c), "event action");
            wr(`CTE_OFF_ACTION, 32'h0);
            wr(`CTE_OFF_FLAGS, 32'hffff_ffff);
         end
      end
      $display("test actions done");
      for (int b = 0; b < 32; b++) begin
         if (exp_valid() & (32'h1 << b)) begin
            wr(`CTE_OFF_MASK_SET, 32'h1 << b);
            @(posedge pclk);
            fire <= 32'h1 << b;
            @(posedge pclk);
            fire <= 32'h0;
            wait_irq(1);
            rd_chk(`CTE_OFF_FLAGS, 32'h1 << b, "flag set");
            wr(`CTE_OFF_MASK_CLR, 32'h1 << b);
            wait_irq(0);
            wr(`CTE_OFF_MASK_SET, 32'h1 << b);
            wait_irq(1);
            wr(`CTE_OFF_FLAGS, 32'h1 << b);
            wait_irq(0);
            rd_chk(`CTE_OFF_FLAGS, 32'h0, "flag cleared");
            wr(`CTE_OFF_MASK_CLR, 32'h1 << b);
         end
      end
      $display("test flags done");
      close_out(0);
   end
endmodule // ctl_timer_event_action_irq_enable_tb
`default_nettype wire
